// ---- src/standard_timer_params.svh ----
// Register map, field positions, reset values and timing counts of the standard timer.
// Assumes a 32-bit AHB-Lite register bus; every register takes one aligned word.
`ifndef STANDARD_TIMER_PARAMS_SVH
`define STANDARD_TIMER_PARAMS_SVH

`define OFS_CTRL0        8'h00
`define OFS_CTRL1        8'h04
`define OFS_CNT_LOW      8'h08
`define OFS_CNT_HIGH     8'h0c
`define OFS_CMPA_LOW     8'h10
`define OFS_CMPA_HIGH    8'h14
`define OFS_FLAGS        8'h18

`define CTRL0_PAUSE      7
`define CTRL0_CLKSEL_HI  6
`define CTRL0_CLKSEL_LO  4
`define CTRL0_RUN        3
`define CTRL0_COMPARE_P_PERIOD_HI    2
`define CTRL0_COMPARE_P_PERIOD_LO    0

`define FLAG_A           0
`define FLAG_P           1

`define CTRL0_RESET      8'h00
`define CTRL1_RESET      8'h00
`define CMPA_RESET       10'h000
`define CNT_MAX          10'h3ff
`define DIV4_CLKSEL      3'h0
`define DIV4_COUNT       2'h3

`endif

// ---- src/standard_timer_pkg.sv ----
// Types shared by the standard timer: operating modes, output actions, control fields.
// Assumes the constants of standard_timer_params.svh for the bit positions.
package standard_timer_pkg;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'h0,
      MODE_CAPTURE = 2'h1,
      MODE_PWM     = 2'h2,
      MODE_TIMER   = 2'h3
   } mode_t;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_LOW    = 2'h1,
      ACT_HIGH   = 2'h2,
      ACT_TOGGLE = 2'h3
   } action_t;

   typedef struct packed {
      mode_t   operatingMode;
      action_t outputFunction;
      logic    outputInitialLevelBit;
      logic    outputInvertBit;
      logic    periodDutySwapBit;
      logic    counterClearSelectBit;
   } ctrl1_t;

   typedef struct packed {
      logic       pause;
      logic [2:0] clockSelect;
      logic       counterRunBit;
      logic [2:0] compareP;
   } ctrl0_t;

endpackage

// ---- src/standard_timer.sv ----
// Standard 10-bit timer with compare-match and PWM output, reached over AHB-Lite.
// Assumes a single master, single word transfers, and a system clock driving all logic.
`timescale 1ns/1ps
`include "standard_timer_params.svh"

// How it works
// - Run bit rising restores pin initial level
// - Initial level bit sets pre-match pin level
// - Initial level bit sets PWM active level
// - Timer/counter mode ignores level and invert
// - Invert bit inverts the output pin
// - Swap bit exchanges PWM period and duty
// - Clear select picks A match or P/overflow
// - Overflow clear only when period bits zero
// - Clear select ignored in PWM, pulse, capture
// - Counter readable only, split low/high bytes
// - Compare A readable, writable, split bytes
// - Mode field zero selects compare output
// - Clear select low raises A and P flags outside single pulse
// - Clear select high in compare and timer modes never raises P flag
// - Of A and P matches, only A changes the compare output
// - A match drives high, low or toggles
// - Function field: none, low, high, toggle
// - Run rise zeroes counter, fall holds it
// - P compares top three counter bits, low seven must be zero
// - High read latches low; low write buffered
module standard_timer
   import standard_timer_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             timerOut,
   output logic             timerOutEn
);

   ctrl0_t      ctrl0_ff;
   ctrl1_t      ctrl1_ff;
   logic [9:0]  count_ff;
   logic [9:0]  compareA_ff;
   logic [7:0]  byteBuf_ff;
   logic [1:0]  flags_ff;
   logic        runPrev_ff;
   logic        pinLevel_ff;
   logic [1:0]  prescale_ff;
   logic        wrPend_ff;
   logic        rdPend_ff;
   logic [7:0]  addr_ff;
   logic [31:0] hrdata_ff;
   logic        hreadyout_ff;
   logic        timerOut_ff;
   logic        timerOutEn_ff;
   logic        hresp_ff;

   logic        take;
   logic        wrEn;
   logic        runRise;
   logic        tick;
   logic [9:0]  cntNext;
   logic        matchA;
   logic        matchP;
   logic        overflow;
   logic        clearA;
   logic        clearByA;
   logic        clearByP;
   logic        singlePulse;
   logic [10:0] duty;
   logic        pwmActive;
   logic        rawLevel;
   logic [31:0] rdValue;

   assign hrdata     = hrdata_ff;
   assign hreadyout  = hreadyout_ff;
   assign hresp      = hresp_ff;
   assign timerOut   = timerOut_ff;
   assign timerOutEn = timerOutEn_ff;

   // Bus front end: writes take no wait state, reads take one so read data comes from a flop
   assign take = hsel && htrans[1] && hready;
   assign wrEn = wrPend_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPend_ff    <= 1'b0;
         rdPend_ff    <= 1'b0;
         addr_ff      <= 8'h00;
         hreadyout_ff <= 1'b1;
         hrdata_ff    <= 32'h0000_0000;
      end else begin
         wrPend_ff <= take && hwrite;
         rdPend_ff <= take && !hwrite;
         if (take) begin
            addr_ff <= haddr;
         end
         hreadyout_ff <= !(take && !hwrite);
         if (rdPend_ff) begin
            hrdata_ff <= rdValue;
         end
      end
   end

   // Always OKAY: no access can fail, unmapped offsets simply read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
      end
   end

   always_comb begin
      rdValue = 32'h0000_0000;
      case (addr_ff)
         `OFS_CTRL0:     rdValue = {24'h000000, ctrl0_ff};
         `OFS_CTRL1:     rdValue = {24'h000000, ctrl1_ff};
         `OFS_CNT_LOW:   rdValue = {24'h000000, byteBuf_ff};
         `OFS_CNT_HIGH:  rdValue = {30'h00000000, count_ff[9:8]};
         `OFS_CMPA_LOW:  rdValue = {24'h000000, byteBuf_ff};
         `OFS_CMPA_HIGH: rdValue = {30'h00000000, compareA_ff[9:8]};
         `OFS_FLAGS:     rdValue = {30'h00000000, flags_ff};
         default:        rdValue = 32'h0000_0000;
      endcase
   end

   // One shared byte buffer, as the two register pairs are never accessed interleaved
   always_ff @(posedge clk) begin
      if (reset) begin
         byteBuf_ff <= 8'h00;
      end else if (rdPend_ff && addr_ff == `OFS_CNT_HIGH) begin
         byteBuf_ff <= count_ff[7:0];
      end else if (rdPend_ff && addr_ff == `OFS_CMPA_HIGH) begin
         byteBuf_ff <= compareA_ff[7:0];
      end else if (wrEn && addr_ff == `OFS_CMPA_LOW) begin
         byteBuf_ff <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         compareA_ff <= `CMPA_RESET;
      end else if (wrEn && addr_ff == `OFS_CMPA_HIGH) begin
         compareA_ff <= {hwdata[1:0], byteBuf_ff};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl1_ff <= `CTRL1_RESET;
      end else if (wrEn && addr_ff == `OFS_CTRL1) begin
         ctrl1_ff <= hwdata[7:0];
      end
   end

   // Single pulse ends by clearing the run bit itself on an A match
   assign singlePulse = ctrl1_ff.operatingMode == MODE_PWM && ctrl1_ff.outputFunction == ACT_TOGGLE;

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl0_ff <= `CTRL0_RESET;
      end else if (wrEn && addr_ff == `OFS_CTRL0) begin
         ctrl0_ff <= hwdata[7:0];
      end else if (singlePulse && matchA) begin
         ctrl0_ff.counterRunBit <= 1'b0;
      end
   end

   // Counter and comparators
   assign runRise = ctrl0_ff.counterRunBit && !runPrev_ff;
   assign tick    = ctrl0_ff.counterRunBit && !ctrl0_ff.pause && !runRise &&
                    (ctrl0_ff.clockSelect != `DIV4_CLKSEL || prescale_ff == `DIV4_COUNT);
   assign cntNext  = count_ff + 10'h001;
   assign matchA   = tick && cntNext == compareA_ff;
   assign matchP   = tick && ctrl0_ff.compareP != 3'h0 &&
                     cntNext[9:7] == ctrl0_ff.compareP && cntNext[6:0] == 7'h00;
   assign overflow = tick && count_ff == `CNT_MAX && ctrl0_ff.compareP == 3'h0;
   assign clearA   = (ctrl1_ff.operatingMode == MODE_COMPARE || ctrl1_ff.operatingMode == MODE_TIMER) &&
                     ctrl1_ff.counterClearSelectBit;
   always_comb begin
      clearByA = 1'b0;
      clearByP = 1'b0;
      case (ctrl1_ff.operatingMode)
         MODE_PWM: begin
            clearByA = !singlePulse && ctrl1_ff.periodDutySwapBit;
            clearByP = !singlePulse && !ctrl1_ff.periodDutySwapBit;
         end
         MODE_CAPTURE: clearByP = 1'b1;
         default: begin
            clearByA = clearA;
            clearByP = !clearA;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         runPrev_ff  <= 1'b0;
         prescale_ff <= 2'h0;
      end else begin
         runPrev_ff  <= ctrl0_ff.counterRunBit;
         prescale_ff <= runRise ? 2'h0 : prescale_ff + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_ff <= 10'h000;
      end else if (runRise) begin
         count_ff <= 10'h000;
      end else if (tick) begin
         if ((clearByA && matchA) || (clearByP && (matchP || overflow))) begin
            count_ff <= 10'h000;
         end else begin
            count_ff <= cntNext;
         end
      end
   end

   // Flags: a match in the clearing cycle wins over the software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         flags_ff <= 2'h0;
      end else begin
         if (matchA) begin
            flags_ff[`FLAG_A] <= 1'b1;
         end else if (wrEn && addr_ff == `OFS_FLAGS && hwdata[`FLAG_A]) begin
            flags_ff[`FLAG_A] <= 1'b0;
         end
         if (matchP && !clearA && !singlePulse) begin
            flags_ff[`FLAG_P] <= 1'b1;
         end else if (wrEn && addr_ff == `OFS_FLAGS && hwdata[`FLAG_P]) begin
            flags_ff[`FLAG_P] <= 1'b0;
         end
      end
   end

   // Compare-match pin state
   always_ff @(posedge clk) begin
      if (reset) begin
         pinLevel_ff <= 1'b0;
      end else if (runRise) begin
         pinLevel_ff <= ctrl1_ff.outputInitialLevelBit;
      end else if (matchA) begin
         case (ctrl1_ff.outputFunction)
            ACT_LOW:    pinLevel_ff <= 1'b0;
            ACT_HIGH:   pinLevel_ff <= 1'b1;
            ACT_TOGGLE: pinLevel_ff <= !pinLevel_ff;
            default:    pinLevel_ff <= pinLevel_ff;
         endcase
      end
   end

   // PWM: a duty at or above the period gives a constant active level
   assign duty = ctrl1_ff.periodDutySwapBit ?
                 ((ctrl0_ff.compareP == 3'h0) ? 11'h400 : {1'b0, ctrl0_ff.compareP, 7'h00}) :
                 {1'b0, compareA_ff};
   always_comb begin
      case (ctrl1_ff.outputFunction)
         ACT_LOW:    pwmActive = 1'b1;
         ACT_HIGH:   pwmActive = ctrl0_ff.counterRunBit && {1'b0, count_ff} < duty;
         ACT_TOGGLE: pwmActive = ctrl0_ff.counterRunBit;
         default:    pwmActive = 1'b0;
      endcase
   end

   always_comb begin
      if (ctrl1_ff.operatingMode == MODE_PWM) begin
         rawLevel = pwmActive ? ctrl1_ff.outputInitialLevelBit : !ctrl1_ff.outputInitialLevelBit;
      end else begin
         rawLevel = pinLevel_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timerOut_ff   <= 1'b0;
         timerOutEn_ff <= 1'b0;
      end else if (ctrl1_ff.operatingMode == MODE_COMPARE || ctrl1_ff.operatingMode == MODE_PWM) begin
         timerOut_ff   <= rawLevel ^ ctrl1_ff.outputInvertBit;
         timerOutEn_ff <= 1'b1;
      end else begin
         timerOut_ff   <= 1'b0;
         timerOutEn_ff <= 1'b0;
      end
   end

   a_run_zeroes_count: assert property (@(posedge clk) disable iff (reset)
      $rose(ctrl0_ff.counterRunBit) |=> count_ff == 10'h000)
      else $error("Counter not zero after run bit rise");

   a_initial_pin_level: assert property (@(posedge clk) disable iff (reset)
      ($rose(ctrl0_ff.counterRunBit) && ctrl1_ff.operatingMode == MODE_COMPARE)
      |=> pinLevel_ff == ctrl1_ff.outputInitialLevelBit
      ##1 timerOut_ff == ($past(pinLevel_ff) ^ ctrl1_ff.outputInvertBit))
      else $error("Pin did not return to initial level");

   a_flag_a_sticky: assert property (@(posedge clk) disable iff (reset)
      (flags_ff[0] && !(wrEn && addr_ff == `OFS_FLAGS && hwdata[0])) |=> flags_ff[0])
      else $error("Compare A flag dropped without clear");

   a_no_p_flag: assert property (@(posedge clk) disable iff (reset)
      (clearA && !flags_ff[1]) |=> !flags_ff[1])
      else $error("P flag raised with A clear selected");

   a_timer_pin_off: assert property (@(posedge clk) disable iff (reset)
      ctrl1_ff.operatingMode == MODE_TIMER |=> !timerOutEn && !timerOut)
      else $error("Pin driven in timer/counter mode");

   a_clear_on_a: assert property (@(posedge clk) disable iff (reset)
      (clearA && matchA && !runRise) |=> count_ff == 10'h000)
      else $error("Counter not cleared on A match");

   a_toggle_on_a: assert property (@(posedge clk) disable iff (reset)
      (matchA && ctrl1_ff.outputFunction == ACT_TOGGLE) |=> pinLevel_ff != $past(pinLevel_ff))
      else $error("Pin did not toggle on A match");

   a_p_keeps_pin: assert property (@(posedge clk) disable iff (reset)
      (matchP && !matchA && !runRise) |=> $stable(pinLevel_ff))
      else $error("P match changed the pin");

   a_read_one_wait: assert property (@(posedge clk) disable iff (reset)
      (take && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong");

   a_a_flag_set: assert property (@(posedge clk) disable iff (reset)
      matchA |=> flags_ff[`FLAG_A])
      else $error("A flag not set on A match");

   a_p_flag_set: assert property (@(posedge clk) disable iff (reset)
      (matchP && ctrl1_ff.operatingMode == MODE_COMPARE && !ctrl1_ff.counterClearSelectBit)
      |=> flags_ff[`FLAG_P])
      else $error("P flag not set on P match");

   a_count_no_write: assert property (@(posedge clk) disable iff (reset)
      (!tick && !runRise) |=> $stable(count_ff))
      else $error("Counter moved without a tick");

   a_off_holds_count: assert property (@(posedge clk) disable iff (reset)
      !ctrl0_ff.counterRunBit |=> $stable(count_ff))
      else $error("Counter moved while off");

   a_invert_pin: assert property (@(posedge clk) disable iff (reset)
      ctrl1_ff.operatingMode == MODE_COMPARE
      |=> timerOut_ff == ($past(pinLevel_ff) ^ $past(ctrl1_ff.outputInvertBit)))
      else $error("Pin polarity wrong");

   a_pwm_forced: assert property (@(posedge clk) disable iff (reset)
      (ctrl1_ff.operatingMode == MODE_PWM && ctrl1_ff.outputFunction == ACT_LOW)
      |=> timerOut_ff == ($past(ctrl1_ff.outputInitialLevelBit) ^ $past(ctrl1_ff.outputInvertBit)))
      else $error("Forced PWM level wrong");

   a_swap_clear_a: assert property (@(posedge clk) disable iff (reset)
      (ctrl1_ff.operatingMode == MODE_PWM && !singlePulse && ctrl1_ff.periodDutySwapBit && matchA)
      |=> count_ff == 10'h000)
      else $error("Swapped PWM period not ended by A match");

   a_period_clear_p: assert property (@(posedge clk) disable iff (reset)
      (ctrl1_ff.operatingMode == MODE_PWM && !singlePulse && !ctrl1_ff.periodDutySwapBit && matchP)
      |=> count_ff == 10'h000)
      else $error("PWM period not ended by P match");

   a_high_read_latch: assert property (@(posedge clk) disable iff (reset)
      (rdPend_ff && addr_ff == `OFS_CNT_HIGH) |=> {2'b00, byteBuf_ff} == ($past(count_ff) & 10'h0ff))
      else $error("Counter low byte not latched on high read");

   a_cmpa_commit: assert property (@(posedge clk) disable iff (reset)
      (wrEn && addr_ff == `OFS_CMPA_HIGH) |=> compareA_ff[7:0] == $past(byteBuf_ff))
      else $error("Compare A low byte not committed");

endmodule

// ---- tb/pin_load.sv ----
// Load on the timer output pin, standing for the board outside the timer.
// Assumes the enable is high while the timer drives the pin.
`timescale 1ns/1ps

module pin_load (
   input  wire logic timerOut,
   input  wire logic timerOutEn,
   output logic      pinLevel
);
   // A released pin settles at the pull-down level, never at the last driven value
   assign pinLevel = timerOutEn ? timerOut : 1'b0;
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the standard timer: registers over AHB-Lite, compare pin, flags.
// Assumes the timer is the only slave, so its hreadyout is the bus hready.
`timescale 1ns/1ps
`include "standard_timer_params.svh"
`define CHECK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nMismatch++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module tb
   import standard_timer_pkg::*;
;
   logic        clk;
   logic        reset;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        timerOut;
   logic        timerOutEn;
   logic        pinLevel;
   int          nMismatch;
   int          testsRun;

   standard_timer i_standard_timer (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timerOut(timerOut),
      .timerOutEn(timerOutEn));
   pin_load i_pin_load (.timerOut(timerOut), .timerOutEn(timerOutEn), .pinLevel(pinLevel));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic finalReport;
      if (nMismatch == 0 && testsRun > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait: a slave that never answers ends the run instead of hanging it
   task automatic waitReady;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
         nMismatch++;
         finalReport();
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      waitReady();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      waitReady();
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      `CHECK(nm, ex, q)
   endtask

   // High byte first, so the low byte comes from the same instant
   task automatic rdCnt(output logic [9:0] v);
      logic [31:0] h;
      logic [31:0] l;
      bus(`OFS_CNT_HIGH, 1'b0, 32'h0, h);
      bus(`OFS_CNT_LOW, 1'b0, 32'h0, l);
      v = {h[1:0], l[7:0]};
   endtask

   task automatic setCmpA(input logic [9:0] v);
      wr(`OFS_CMPA_LOW, {24'h0, v[7:0]});
      wr(`OFS_CMPA_HIGH, {30'h0, v[9:8]});
   endtask

   // Stop, clear flags, configure, then run on the every-cycle clock with compare-P = 1
   task automatic start(input ctrl1_t c);
      wr(`OFS_CTRL0, 32'h10);
      wr(`OFS_FLAGS, 32'h3);
      wr(`OFS_CTRL1, {24'h0, c});
      wr(`OFS_CTRL0, 32'h19);
   endtask

   task automatic resetValues;
      `CHECK("enable after reset", 1'b1, timerOutEn)
      `CHECK("pin after reset", 1'b0, pinLevel)
      for (int i = 0; i < 8; i++) begin
         rdChk(8'(i * 4), 32'h0, "reset value");
      end
   endtask

   task automatic byteAccess;
      wr(`OFS_CNT_LOW, 32'hff);
      wr(`OFS_CNT_HIGH, 32'h3);
      rdChk(`OFS_CNT_HIGH, 32'h0, "counter high");
      rdChk(`OFS_CNT_LOW, 32'h0, "counter low");
      setCmpA(10'h2a5);
      wr(`OFS_CMPA_LOW, 32'h3c);
      rdChk(`OFS_CMPA_HIGH, 32'h2, "compare high");
      rdChk(`OFS_CMPA_LOW, 32'ha5, "compare low");
   endtask

   task automatic compareOutput;
      action_t    fn[5] = '{ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE, ACT_TOGGLE};
      logic       ini[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      ctrl1_t     c;
      logic       e;
      logic [9:0] v;
      setCmpA(10'd100);
      for (int i = 0; i < 5; i++) begin
         c = '{MODE_COMPARE, fn[i], ini[i], i[0], 1'b0, 1'b0};
         start(c);
         cyc(5);
         `CHECK("initial pin", ini[i] ^ i[0], pinLevel)
         cyc(100);
         e = (fn[i] == ACT_NONE) ? ini[i] : (fn[i] == ACT_TOGGLE) ? ~ini[i] : fn[i][1];
         `CHECK("pin after A match", e ^ i[0], pinLevel)
         rdChk(`OFS_FLAGS, 32'h1, "A flag only");
         cyc(30);
         rdChk(`OFS_FLAGS, 32'h3, "both flags");
         `CHECK("pin after P match", e ^ i[0], pinLevel)
         rdCnt(v);
         `CHECK("cleared by P match", 1'b1, v < 10'd40)
      end
   endtask

   task automatic clearOnA;
      logic [9:0] v;
      setCmpA(10'd200);
      start('{MODE_COMPARE, ACT_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1});
      cyc(450);
      rdChk(`OFS_FLAGS, 32'h1, "no P flag");
      rdCnt(v);
      `CHECK("cleared by A match", 1'b1, v < 10'd200)
   endtask

   task automatic stopHolds;
      logic [9:0] a;
      logic [9:0] b;
      wr(`OFS_CTRL0, 32'h11);
      rdCnt(a);
      cyc(20);
      rdCnt(b);
      `CHECK("held count", a, b)
      wr(`OFS_CTRL0, 32'h19);
      rdCnt(b);
      `CHECK("restart from zero", 1'b1, b < 10'd10)
   endtask

   task automatic modes;
      for (int m = 0; m < 4; m++) begin
         start('{mode_t'(m), ACT_NONE, 1'b1, 1'b1, 1'b0, 1'b0});
         cyc(2);
         `CHECK("pin enable", (m == 0 || m == 2), timerOutEn)
      end
      `CHECK("released pin", 1'b0, pinLevel)
   endtask

   task automatic pwmForce;
      for (int i = 0; i < 4; i++) begin
         start('{MODE_PWM, i[0] ? ACT_LOW : ACT_NONE, i[1], 1'b0, 1'b0, 1'b0});
         cyc(4);
         `CHECK("forced level", i[0] ? i[1] : ~i[1], pinLevel)
      end
   endtask

   task automatic countHigh(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge clk);
         if (pinLevel === 1'b1) begin
            k++;
         end
      end
   endtask

   // Whole periods are counted, so the result does not depend on where sampling starts
   task automatic pwmWave;
      int k;
      setCmpA(10'd32);
      start('{MODE_PWM, ACT_HIGH, 1'b1, 1'b0, 1'b0, 1'b1});
      cyc(200);
      countHigh(128, k);
      `CHECK("duty from compare A", 32, k)
      setCmpA(10'd300);
      start('{MODE_PWM, ACT_HIGH, 1'b0, 1'b1, 1'b1, 1'b0});
      cyc(400);
      countHigh(300, k);
      `CHECK("duty from compare P", 128, k)
   endtask

   task automatic pulseOnce;
      setCmpA(10'd50);
      start('{MODE_PWM, ACT_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b0});
      cyc(10);
      `CHECK("pulse active", 1'b1, pinLevel)
      cyc(60);
      `CHECK("pulse ended", 1'b0, pinLevel)
      rdChk(`OFS_CTRL0, 32'h11, "run cleared by A");
      rdChk(`OFS_FLAGS, 32'h1, "pulse flag");
   endtask

   task automatic slowAndPause;
      logic [9:0] a;
      logic [9:0] b;
      setCmpA(10'd1000);
      start('{MODE_COMPARE, ACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0});
      wr(`OFS_CTRL0, 32'h01);
      wr(`OFS_CTRL0, 32'h09);
      cyc(40);
      rdCnt(a);
      `CHECK("divided count", 1'b1, a >= 10'd8 && a <= 10'd12)
      wr(`OFS_CTRL0, 32'h89);
      rdCnt(a);
      cyc(20);
      rdCnt(b);
      `CHECK("paused count", a, b)
   endtask

   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      nMismatch = 0;
      testsRun = 0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      cyc(2);
      resetValues();
      byteAccess();
      compareOutput();
      clearOnA();
      stopHolds();
      modes();
      pwmForce();
      pwmWave();
      pulseOnce();
      slowAndPause();
      finalReport();
   end
endmodule
